// file: bench/sic_prog_model.sv
// programmer model: drives the mode pin, serial clock and data, samples return
// assumes a 200 MHz core clock; every pin change on its falling edge
`timescale 1ns/1ps
module sic_prog_model #(
    parameter int ENTRY_CYC = 64   // entry wait, shortened to keep the run short
)
(
    input  wire logic core_clk_i,
    input  wire logic miso_i,
    output logic      prog_b_o,
    output logic      sck_o,
    output logic      mosi_o
);
    // ==========================================================
    // pins at rest
    // ==========================================================
    initial
    begin
        prog_b_o = 1'b1;
        sck_o    = 1'b0;   // idles low, no stray edge
        mosi_o   = 1'b0;
    end

    // enter programming mode, wait before the first command
    task automatic enter();
    begin
        @(negedge core_clk_i);
        prog_b_o = 1'b0;
        repeat (ENTRY_CYC) @(negedge core_clk_i);
    end
    endtask

    // leave programming mode; clears any misalignment
    task automatic leave();
    begin
        @(negedge core_clk_i);
        prog_b_o = 1'b1;
        repeat (16) @(negedge core_clk_i);
    end
    endtask

    // one whole four-byte command, msb first, 160 ns clock period
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        int i;
    begin
        for (i = 31; i >= 0; i--)
        begin
            mosi_o = cmd[i];
            repeat (16) @(negedge core_clk_i);
            sck_o  = 1'b1;   // sample on rise
            rsp[i] = miso_i;
            repeat (16) @(negedge core_clk_i);
            sck_o  = 1'b0;
        end
    end
    endtask
endmodule

// file: bench/test_serial_isp_command_slave.sv
// self-checking bench of the command slave in byte and page write modes
// assumes the programmer model drives the link; pull-up on the return line
`timescale 1ns/1ps
module test_serial_isp_command_slave;
    import sic_pkg::*;
    localparam int WR_N = 2000;   // long enough to read during a write
    logic        core_clk;
    logic        rst_b;
    logic        prog_b;
    logic        sck;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    logic        unlocked;
    logic        wr_busy;
    logic        miso2;
    logic        miso_oe2;
    logic        wr_busy2;
    logic        sel;
    logic [1:0]  lock_b;
    logic [31:0] rsp;
    int          fail_count;
    int          checks_done;
    // programmer pull-up; sel picks which part answers
    wire         miso_line = sel ? (miso_oe2 ? miso2 : 1'b1) : (miso_oe ? miso : 1'b1);

    // ==========================================================
    // clock, design and partner
    // ==========================================================
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    sic_cmd_slave #(.WR_CYC_P(WR_N), .PAGE_MODE(1'b0)) u_sic_cmd_slave (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .ce_i(1'b1), .prog_b_i(prog_b),
        .sck_i(sck), .mosi_i(mosi), .lock_b_i(lock_b), .miso_o(miso),
        .miso_oe_o(miso_oe), .unlocked_o(unlocked), .wr_busy_o(wr_busy));
    // page mode part with a blank signature, in lockstep on the same link
    sic_cmd_slave #(.WR_CYC_P(WR_N), .SIG_BLANK(1'b1)) u_sic_cmd_slave_pg (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .ce_i(1'b1), .prog_b_i(prog_b),
        .sck_i(sck), .mosi_i(mosi), .lock_b_i(lock_b), .miso_o(miso2),
        .miso_oe_o(miso_oe2), .unlocked_o(), .wr_busy_o(wr_busy2));
    sic_prog_model u_sic_prog_model (.core_clk_i(core_clk), .miso_i(miso_line),
        .prog_b_o(prog_b), .sck_o(sck), .mosi_o(mosi));

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    // send one command; first slot not compared, it holds the previous tail
    task automatic cmd(input logic [31:0] c, input logic [23:0] exp);
    begin
        u_sic_prog_model.xfer(c, rsp);
        chk("return bytes", {8'h00, rsp[23:0]}, {8'h00, exp});
    end
    endtask

    // wait for the write cycle to end, bounded
    task automatic wait_idle();
        int n;
    begin
        n = 0;
        while (wr_busy !== 1'b0 && n < 4000)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("write done", {31'h0, wr_busy}, 32'h0);
    end
    endtask

    task automatic complete_run();
    begin
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_entry();
    begin
        chk("oe after reset", {31'h0, miso_oe}, 32'h0);
        u_sic_prog_model.enter();
        cmd(32'h3000_0000, 24'hffffff);
        chk("locked out", {31'h0, unlocked}, 32'h0);
        cmd(32'hac53_0000, 24'hff5300);
        chk("unlocked", {30'h0, unlocked, miso_oe}, 32'h3);
    end
    endtask

    task automatic t_signature();
        logic [7:0] exp [4];
    begin
        exp = '{8'h5a, 8'hc1, 8'h3c, 8'h03};   // defaults of the design, then index 03 echoed back
        for (int i = 0; i < 4; i++)
            cmd({16'h3000, 8'(i), 8'h00}, {16'h3000, exp[i]});
    end
    endtask

    task automatic t_byte_write();
    begin
        cmd(32'h6000_05ab, 24'h600005);
        chk("busy", {31'h0, wr_busy}, 32'h1);
        cmd(32'h2000_0500, 24'h2000ff);
        wait_idle();
        cmd(32'h6800_05cd, 24'h680005);
        wait_idle();
        cmd(32'h2800_0500, 24'h2800cd);
        cmd(32'h2000_0500, 24'h2000ab);
    end
    endtask

    // page commands in byte mode, then both lock levels
    task automatic t_refused();
    begin
        cmd(32'h4000_0599, 24'h400005);
        cmd(32'h4c00_0000, 24'h4c0000);
        repeat (20) @(negedge core_clk);
        chk("no page write", {31'h0, wr_busy}, 32'h0);
        lock_b = 2'b10;
        cmd(32'h6000_0577, 24'h600005);
        repeat (20) @(negedge core_clk);
        chk("no locked write", {31'h0, wr_busy}, 32'h0);
        cmd(32'h2000_0500, 24'h2000ab);
        lock_b = 2'b00;
        cmd(32'h3000_0100, 24'h300001);
        cmd(32'h2000_0500, 24'h200005);
        lock_b = 2'b11;
    end
    endtask

    // page part: blank signature, load, commit, poll, fixed wait, read back
    task automatic t_page();
    begin
        sel = 1'b1;
        cmd(32'h3000_0100, 24'h3000ff);
        cmd(32'h4800_0b5e, 24'h48000b);
        cmd(32'h4c00_0000, 24'h4c0000);
        chk("page busy", {31'h0, wr_busy2}, 32'h1);
        cmd(32'h2800_0b00, 24'h2800ff);
        repeat (WR_N + 100) @(negedge core_clk);
        cmd(32'h2800_0b00, 24'h28005e);
        sel = 1'b0;
    end
    endtask

    task automatic t_reenter();
    begin
        u_sic_prog_model.leave();
        chk("left mode", {30'h0, unlocked, miso_oe}, 32'h0);
        u_sic_prog_model.enter();
        cmd(32'h3000_0000, 24'hffffff);
    end
    endtask

    // ==========================================================
    // main sequence and watchdog
    // ==========================================================
    initial
    begin
        fail_count  = 0;
        checks_done = 0;
        rst_b       = 1'b0;
        sel         = 1'b0;
        lock_b      = 2'b11;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        t_entry();
        t_signature();
        t_byte_write();
        t_refused();
        t_page();
        t_reenter();
        complete_run();
    end

    // about 23 commands of 5 us plus write waits, near 150 us; twice that
    initial
    begin
        #300000;
        fail_count++;
        complete_run();
    end
endmodule

// file: hw/sic_cmd_slave.sv
// serial programming command slave: four-byte commands over a three-wire link
// assumes pins arrive unsynchronised; flash array lives here; no chip erase
//
// Behaviour
// RULE1 - programming pin low enables the serial command engine
// RULE2 - programmer waits at least 20 ms after entering before commanding; the bench model waits ENTRY_CYC (64) core clocks
// RULE3 - programmer keeps the serial clock still until commands begin
// RULE4 - every command is four bytes: opcode, address high, address low, data
// RULE5 - each slot returns the byte received in the previous slot
// RULE6 - memory reads return their byte in the fourth slot
// RULE7 - both data lines carry each byte most significant bit first
// RULE8 - only the unlock command AC 53 is honoured until unlocked
// RULE9 - unlock gives no acknowledge; signature reads confirm it
// RULE10 - once unlocked, memory access obeys the lock bits
// RULE11 - signature read is 30, index in byte three up to 02
// RULE12 - signatures are vendor, family with size nibble, part number
// RULE13 - an unprogrammed signature reads as FF
// RULE14 - programmer treats an echoed FF command as a missing target
// RULE15 - with both lock bits set, byte four echoes the address byte
// RULE16 - programmer erases the chip before programming flash; the design has no chip erase and the bench writes without one
// RULE17 - exactly one flash write mode, byte or page
// RULE18 - flash read 20 or 28 selects low or high byte of a word
// RULE19 - byte mode writes byte four with commands 60 or 68
// RULE20 - page mode loads a page buffer then commits it in one write
// RULE21 - programmer waits a fixed time after each write; the bench polls wr_busy after byte writes
// RULE22 - reads of a location being written return FF until done
// RULE23 - synchronised slave echoes 53 in slot three of unlock
// RULE24 - data output stays undriven until the unlock is received
// RULE25 - programmer sends all four unlock bytes before anything else; the bench sends a signature read 30 first after each entry
// RULE26 - programmer releases the programming pin to end an erase
// RULE27 - data sampled on rising clock edge, output changes on falling
`timescale 1ns/1ps
module sic_cmd_slave
    import sic_pkg::*;
#(
    parameter int unsigned WR_CYC_P   = WR_CYC,
    parameter bit          PAGE_MODE  = 1'b1,
    parameter bit          SIG_BLANK  = 1'b0,
    parameter logic [7:0]  SIG_VENDOR = 8'h5a,   // arbitrary value
    parameter logic [7:0]  SIG_FAMILY = 8'hc1,   // arbitrary, size nibble 1
    parameter logic [7:0]  SIG_PART   = 8'h3c    // arbitrary value
)
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       ce_i,
    input  wire logic       prog_b_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic [1:0] lock_b_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    output logic            unlocked_o,
    output logic            wr_busy_o
);

    sic_state_t      q;
    sic_state_t      d;
    logic [7:0]      flash_mem [0:FLASH_BYTES-1];
    logic [7:0]      page_buf  [0:PAGE_BYTES-1];
    logic            rise;
    logic            fall;
    logic            in_prog;
    logic            byte_done;
    logic [7:0]      rxb;
    logic [FA_W-1:0] cmd_a;
    logic [7:0]      rd_byte;
    logic            lock_wr;
    logic            lock_rd;
    logic            busy_hit;
    logic            push;
    logic            pb_we;
    logic            f_ready;
    logic            f_valid;
    logic [ENT_W-1:0] f_in;
    logic [ENT_W-1:0] f_out;
    logic            pop;

    // ==========================================================
    // helpers
    // ==========================================================
    // a page write marks the whole page busy for polling
    function automatic logic hits_busy(input logic [FA_W-1:0] a,
                                       input logic [FA_W-1:0] ba,
                                       input logic            pg);
        if (pg)
            hits_busy = (a[FA_W-1:PB_W] == ba[FA_W-1:PB_W]);
        else
            hits_busy = (a == ba);
    endfunction

    // ==========================================================
    // command decode and link logic
    // ==========================================================
    assign in_prog = ~q.rstp_f;                                   // RULE1
    assign lock_wr = ~lock_b_i[0];                                // RULE10
    assign lock_rd = ~lock_b_i[0] & ~lock_b_i[1];                 // RULE15
    assign rxb     = {q.rx_sh[6:0], q.mosi_f};                    // RULE7
    assign cmd_a   = {q.b1[1:0], (q.slot == 2'd3) ? q.b2 : rxb, q.b0[HALF_BIT]}; // RULE18
    assign rd_byte = flash_mem[cmd_a];
    assign busy_hit = (q.wst == W_BUSY) && hits_busy(cmd_a, q.busy_a, q.busy_pg);
    assign pop     = f_valid && (q.wst == W_IDLE);

    always_comb
    begin
        d         = q;
        push      = 1'b0;
        pb_we     = 1'b0;
        f_in      = {1'b0, cmd_a, rxb};
        // three stages; a change counts once stages two and three agree
        d.sck_s   = {q.sck_s[1:0], sck_i};
        d.mosi_s  = {q.mosi_s[1:0], mosi_i};
        d.rstp_s  = {q.rstp_s[1:0], prog_b_i};
        if (q.sck_s[1] == q.sck_s[2])
            d.sck_f = q.sck_s[2];
        if (q.mosi_s[1] == q.mosi_s[2])
            d.mosi_f = q.mosi_s[2];
        if (q.rstp_s[1] == q.rstp_s[2])
            d.rstp_f = q.rstp_s[2];
        rise      = d.sck_f & ~q.sck_f;                           // RULE27
        fall      = ~d.sck_f & q.sck_f;                           // RULE27
        byte_done = rise && in_prog && (q.bit_cnt == 3'd7);

        if (!in_prog)
        begin
            // leaving programming mode drops the unlock and the pin
            d.bit_cnt  = 3'd0;
            d.slot     = 2'd0;
            d.unlocked = 1'b0;
            d.miso_oe  = 1'b0;                                    // RULE24
            d.miso     = 1'b0;
            d.tx_sh    = 8'h00;
        end
        else if (rise)
        begin
            d.rx_sh   = rxb;                                      // RULE27
            d.bit_cnt = q.bit_cnt + 3'd1;
            if (byte_done)
            begin
                d.slot  = q.slot + 2'd1;                          // RULE4
                d.tx_sh = rxb;                                    // RULE5
                case (q.slot)
                    2'd0:
                    begin
                        d.b0 = rxb;
                    end
                    2'd1:
                    begin
                        d.b1 = rxb;
                        // output starts next falling edge with the 53 echo
                        if (q.b0 == OP_UNLOCK0 && rxb == OP_UNLOCK1)
                            d.unlocked = 1'b1;                    // RULE8 RULE23
                    end
                    2'd2:
                    begin
                        d.b2 = rxb;
                        if (q.unlocked && !lock_rd)               // RULE10
                        begin
                            if (q.b0 == OP_SIG)
                            begin
                                if (SIG_BLANK)
                                    d.tx_sh = BLANK_VAL;          // RULE13
                                else if (rxb == 8'h00)
                                    d.tx_sh = SIG_VENDOR;         // RULE11 RULE12
                                else if (rxb == 8'h01)
                                    d.tx_sh = SIG_FAMILY;         // RULE12
                                else if (rxb == SIG_LAST)
                                    d.tx_sh = SIG_PART;           // RULE11
                            end
                            else if (op_match(q.b0, OP_RD))
                            begin
                                if (busy_hit)
                                    d.tx_sh = BUSY_VAL;           // RULE22
                                else
                                    d.tx_sh = rd_byte;            // RULE6 RULE18
                            end
                        end
                    end
                    default:
                    begin
                        // fourth byte: act on the whole command
                        if (q.unlocked && !lock_wr)               // RULE8 RULE10
                        begin
                            if (!PAGE_MODE && op_match(q.b0, OP_WR))
                                push = f_ready;                   // RULE19 RULE17
                            else if (PAGE_MODE && q.b0 == OP_PG_WRITE)
                            begin
                                push = f_ready;                   // RULE20
                                f_in = {1'b1, cmd_a, rxb};
                            end
                            else if (PAGE_MODE && op_match(q.b0, OP_PG_LOAD))
                                pb_we = 1'b1;                     // RULE20
                        end
                    end
                endcase
            end
        end
        else if (fall)
        begin
            // the first fall after a byte presents the new msb
            d.miso    = q.tx_sh[7];                               // RULE7 RULE27
            d.tx_sh   = {q.tx_sh[6:0], 1'b0};
            d.miso_oe = q.unlocked;                               // RULE24 RULE9
        end

        // write engine: one write cycle at a time, buffer holds the rest
        case (q.wst)
            W_IDLE:
            begin
                if (f_valid)
                begin
                    d.wst     = W_BUSY;
                    d.wcnt    = '0;
                    d.busy_a  = f_out[ENT_W-2:8];
                    d.busy_pg = f_out[ENT_W-1];
                end
            end
            W_BUSY:
            begin
                d.wcnt = q.wcnt + {{(WC_W-1){1'b0}}, 1'b1};
                if (q.wcnt == WC_W'(WR_CYC_P - 1))
                    d.wst = W_IDLE;                               // RULE22
            end
            default:
            begin
                d.wst = W_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q        <= '0;
            q.sck_s  <= 3'b000;
            q.rstp_s <= 3'b111;
            q.rstp_f <= 1'b1;
            q.wst    <= W_IDLE;
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    // ==========================================================
    // memories: no reset, contents survive mode changes
    // ==========================================================
    // a page commit copies the whole buffer in one cycle; costs area, keeps it simple
    always_ff @(posedge core_clk_i)
    begin
        if (ce_i)
        begin
            if (pb_we)
                page_buf[cmd_a[PB_W-1:0]] <= rxb;                 // RULE20
            if (pop && f_out[ENT_W-1])
            begin
                for (int i = 0; i < PAGE_BYTES; i++)
                    flash_mem[{f_out[ENT_W-2:8+PB_W], PB_W'(i)}] <= page_buf[i];
            end
            else if (pop)
                flash_mem[f_out[ENT_W-2:8]] <= f_out[7:0];        // RULE19
        end
    end

    // ==========================================================
    // write buffer: holds up to two writes behind a busy write engine; a write arriving while it is full is dropped
    // ==========================================================
    sic_fifo2 #(
        .W (ENT_W)
    ) u_wbuf (
        .clk_i       (core_clk_i),
        .rst_b_i     (rst_b_i),
        .ce_i        (ce_i),
        .in_valid_i  (push),
        .in_ready_o  (f_ready),
        .in_data_i   (f_in),
        .out_valid_o (f_valid),
        .out_ready_i (q.wst == W_IDLE),
        .out_data_o  (f_out)
    );

    // outputs straight from state flops
    assign miso_o     = q.miso;
    assign miso_oe_o  = q.miso_oe;
    assign unlocked_o = q.unlocked;
    assign wr_busy_o  = q.wst[1];

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_slot_done(logic [1:0] n);
        ce_i && byte_done && q.slot == n;
    endsequence

    sequence s_sig_read;
        s_slot_done(2'd2) ##0 (q.unlocked && !lock_rd && q.b0 == OP_SIG);
    endsequence

    property p_drive_after_unlock;
        q.miso_oe |-> q.unlocked;
    endproperty
    a_drive_after_unlock: assert property (p_drive_after_unlock) // RULE24
        else $error("data output driven before unlock");

    property p_unlock_seq;
        (s_slot_done(2'd1) ##0 (q.b0 == OP_UNLOCK0 && rxb == OP_UNLOCK1))
            |=> (q.unlocked && q.tx_sh == OP_UNLOCK1);
    endproperty
    a_unlock_seq: assert property (p_unlock_seq) // RULE23
        else $error("unlock did not arm the 53 echo");

    property p_echo;
        s_slot_done(2'd0) |=> (q.tx_sh == $past(rxb) && q.slot == 2'd1);
    endproperty
    a_echo: assert property (p_echo) // RULE5
        else $error("slot did not echo the previous byte");

    property p_msb_first;
        (ce_i && fall && in_prog) |=> (q.miso == $past(q.tx_sh[7]) && q.tx_sh[0] == 1'b0);
    endproperty
    a_msb_first: assert property (p_msb_first) // RULE7
        else $error("output bit not taken from the top of the shifter");

    property p_locked_echo;
        (s_slot_done(2'd2) ##0 lock_rd) |=> q.tx_sh == $past(rxb);
    endproperty
    a_locked_echo: assert property (p_locked_echo) // RULE15
        else $error("locked part did not echo the address byte");

    property p_sig_part;
        (s_sig_read ##0 (rxb == SIG_LAST && !SIG_BLANK)) |=> q.tx_sh == SIG_PART;
    endproperty
    a_sig_part: assert property (p_sig_part) // RULE11
        else $error("signature index two returned the wrong byte");

    property p_busy_poll;
        (s_slot_done(2'd2) ##0 (q.unlocked && !lock_rd && op_match(q.b0, OP_RD)
            && busy_hit)) |=> q.tx_sh == BUSY_VAL;
    endproperty
    a_busy_poll: assert property (p_busy_poll) // RULE22
        else $error("read of a busy location did not return the busy value");

    property p_locked_no_write;
        (s_slot_done(2'd3) ##0 (lock_wr || !q.unlocked)) |-> !push && !pb_we;
    endproperty
    a_locked_no_write: assert property (p_locked_no_write) // RULE10
        else $error("write accepted while locked or before unlock");

    property p_write_bound;
        (q.wst == W_BUSY) |-> (q.wcnt < WC_W'(WR_CYC_P));
    endproperty
    a_write_bound: assert property (p_write_bound) // RULE21
        else $error("write cycle ran past its time");

    property p_leave_prog;
        (ce_i && $rose(q.rstp_f)) |=> (!q.unlocked && !q.miso_oe && q.slot == 2'd0);
    endproperty
    a_leave_prog: assert property (p_leave_prog) // RULE1
        else $error("leaving programming mode kept the unlock");

endmodule

// file: hw/sic_fifo2.sv
// two-entry buffer with valid and ready on both sides
// assumes both sides on the core clock; ce_i freezes all state
`timescale 1ns/1ps
module sic_fifo2
    import sic_pkg::*;
#(
    parameter int W = ENT_W
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic [1:0]   cnt;
    } sic_fifo_t;

    sic_fifo_t q;
    sic_fifo_t d;
    logic      push;
    logic      pop;

    // ==========================================================
    // head always sits in e0 so the output needs no mux
    // ==========================================================
    always_comb
    begin
        d    = q;
        push = in_valid_i && (q.cnt != 2'd2);
        pop  = out_ready_i && (q.cnt != 2'd0);
        if (pop)
        begin
            d.e0 = q.e1;
        end
        if (push)
        begin
            if (d.cnt - {1'b0, pop} == 2'd0)
                d.e0 = in_data_i;
            else
                d.e1 = in_data_i;
        end
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            q <= '0;
        else if (ce_i)
            q <= d;
    end

    assign in_ready_o  = (q.cnt != 2'd2);
    assign out_valid_o = (q.cnt != 2'd0);
    assign out_data_o  = q.e0;

endmodule

// file: hw/sic_pkg.sv
// shared constants, types and helpers of the serial programming command slave
// assumes one core clock of 200 MHz; the serial pins come from another party
package sic_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_FREQ_MHZ = 200;             // core clock rate
    localparam int WR_TIME_US   = 4000;            // write cycle time
    localparam int WR_CYC       = WR_TIME_US * CLK_FREQ_MHZ;
    localparam int WC_W         = 20;              // write counter width

    // ==========================================================
    // command bytes
    // ==========================================================
    localparam logic [7:0] OP_UNLOCK0  = 8'hac;
    localparam logic [7:0] OP_UNLOCK1  = 8'h53;
    localparam logic [7:0] OP_SIG      = 8'h30;
    localparam logic [7:0] OP_RD       = 8'h20;    // 8'h28 with the half bit
    localparam logic [7:0] OP_WR       = 8'h60;    // 8'h68 with the half bit
    localparam logic [7:0] OP_PG_LOAD  = 8'h40;    // 8'h48 with the half bit
    localparam logic [7:0] OP_PG_WRITE = 8'h4c;
    localparam int         HALF_BIT    = 3;
    localparam logic [7:0] HALF_MASK   = 8'h08;
    localparam logic [7:0] SIG_LAST    = 8'h02;
    localparam logic [7:0] BUSY_VAL    = 8'hff;
    localparam logic [7:0] BLANK_VAL   = 8'hff;

    // ==========================================================
    // memory geometry
    // ==========================================================
    localparam int FA_W        = 11;               // flash byte address
    localparam int PB_W        = 6;                // byte index in a page
    localparam int FLASH_BYTES = 2048;
    localparam int PAGE_BYTES  = 64;
    localparam int ENT_W       = 1 + FA_W + 8;     // page flag, address, data

    // ==========================================================
    // state
    // ==========================================================
    typedef enum logic [1:0] {
        W_IDLE = 2'b01,
        W_BUSY = 2'b10
    } sic_wst_t;

    typedef struct packed {
        logic [2:0]      sck_s;
        logic [2:0]      mosi_s;
        logic [2:0]      rstp_s;
        logic            sck_f;
        logic            mosi_f;
        logic            rstp_f;
        logic [2:0]      bit_cnt;
        logic [1:0]      slot;
        logic [7:0]      rx_sh;
        logic [7:0]      tx_sh;
        logic [7:0]      b0;
        logic [7:0]      b1;
        logic [7:0]      b2;
        logic            unlocked;
        logic            miso;
        logic            miso_oe;
        sic_wst_t        wst;
        logic [WC_W-1:0] wcnt;
        logic [FA_W-1:0] busy_a;
        logic            busy_pg;
    } sic_state_t;

    // command match with the half-select bit ignored
    function automatic logic op_match(input logic [7:0] b, input logic [7:0] op);
        op_match = ((b & ~HALF_MASK) == op);
    endfunction

endpackage
